// [bench/lrca_arbiter_props.sv]
// Concurrent checks on the arbiter's top-level ports.
// Assumes a bind from the bench; all settings synchronous to CLK.
`timescale 1ns/10ps
`default_nettype none
module lrca_arbiter_props
  import lrca_pkg::*;
#(
  parameter int NUM_TERM = LRCA_NUM_TERM
) (
  input wire logic CLK, RST, KEY_PROG_PRESS, KEY_REV_PRESS, REMOTE_MODE, SRC_IND_KEYPAD,
  input wire logic FREQ_IND_KEYPAD, RUN, REVERSE, JOG, DECEL_TO_ZERO,
  input wire logic [3:0] KEY_FUNCTION_SELECT,
  input wire logic [2:0] COMMAND_SOURCE_SELECT,
  input wire logic [1:0] DIRECTION_BLOCK_SELECT,
  input wire logic [NUM_TERM*6-1:0] TERMINAL_FUNCTION_MAP,
  input wire logic [NUM_TERM-1:0] MULTI_FUNCTION_INPUTS
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Accepted toggle press
  wire locrem = (KEY_FUNCTION_SELECT == LRCA_KEY_FN_LOCREM) && KEY_PROG_PRESS;
  // Some asserted terminal carries the run permit function
  logic permit;
  always_comb begin
    permit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++)
      if (TERMINAL_FUNCTION_MAP[i*6+:6] == LRCA_FN_RUN_PERMIT && MULTI_FUNCTION_INPUTS[i]) permit = 1'b1;
  end
  to_local_a: assert property (REMOTE_MODE && locrem |=> !REMOTE_MODE && !RUN)
    else $error("run kept on switch to local");
  toggle_flip_a: assert property (locrem |=> REMOTE_MODE != $past(REMOTE_MODE))
    else $error("mode not toggled");
  key_ignore_a: assert property (KEY_FUNCTION_SELECT != LRCA_KEY_FN_LOCREM && !$past(RST) |=> $stable(REMOTE_MODE))
    else $error("mode moved without toggle function");
  mode_ind_a: assert property (FREQ_IND_KEYPAD == !REMOTE_MODE &&
    SRC_IND_KEYPAD == (!REMOTE_MODE || COMMAND_SOURCE_SELECT == LRCA_SRC_KEYPAD)) else $error("indicator wrong");
  dig_stop_a: assert property (!REMOTE_MODE && locrem && COMMAND_SOURCE_SELECT inside {0, 3, 4, 5}
    |=> REMOTE_MODE && !RUN) else $error("digital source kept running");
  blk_fwd_a: assert property ((DIRECTION_BLOCK_SELECT == LRCA_BLK_FWD)[*2] |-> !(RUN && !REVERSE))
    else $error("forward run while blocked");
  blk_rev_a: assert property ((DIRECTION_BLOCK_SELECT == LRCA_BLK_REV)[*2] |-> !(RUN && REVERSE))
    else $error("reverse run while blocked");
  rev_decel_a: assert property (!REMOTE_MODE && !KEY_PROG_PRESS && KEY_REV_PRESS &&
    DIRECTION_BLOCK_SELECT == LRCA_BLK_REV |=> DECEL_TO_ZERO && !RUN) else $error("blocked reverse not stopped");
  jog_gate_a: assert property (!REMOTE_MODE && !KEY_PROG_PRESS && !permit |=> !JOG)
    else $error("local jog without permit");
  // Main scenarios reached
  cover property (REMOTE_MODE && locrem);
  cover property (DECEL_TO_ZERO);
  cover property (!REMOTE_MODE && JOG);
endmodule
`default_nettype wire

// [bench/lrca_arbiter_test.sv]
// Self-checking bench for the local/remote arbiter.
// Assumes one 250 MHz clock; inputs driven at rising edges.
`timescale 1ns/10ps
`default_nettype none
module lrca_arbiter_test
  import lrca_pkg::*;
;
  logic clk = 0, rst = 1, prog = 0, kfwd = 0, krev = 0, crun = 0, pon = 0, fault = 0, jogreq = 0;
  logic [3:0] fn = 0;
  logic [2:0] src = 0;
  logic [1:0] dblk = 0;
  logic [65:0] tmap = 0;
  logic [14:0] lvl = 0;
  wire fwd_t, rev_t, jog_t, pre_t, remote, sind, find, run, rev, jog, decel, pre;
  wire [10:0] mfi;
  int err_count = 0, compares = 0;
  lrca_term_model #(.NUM_TERM(11)) u_lrca_term_model (.set_lvl(lvl), .fwd_run(fwd_t), .rev_run(rev_t),
    .jog_in(jog_t), .pre_in(pre_t), .mfi(mfi));
  lrca_arbiter u_lrca_arbiter (.CLK(clk), .RST(rst), .KEY_FUNCTION_SELECT(fn), .COMMAND_SOURCE_SELECT(src),
    .POWER_ON_RUN_ENABLE(pon), .DIRECTION_BLOCK_SELECT(dblk), .TERMINAL_FUNCTION_MAP(tmap),
    .FAULT_RESET_POWERUP(fault), .KEY_PROG_PRESS(prog), .KEY_FWD_PRESS(kfwd), .KEY_REV_PRESS(krev),
    .KEY_STOP_PRESS(1'b0), .KEY_JOG_REQ(jogreq), .MULTI_FUNCTION_INPUTS(mfi), .FORWARD_RUN_INPUT(fwd_t),
    .REVERSE_RUN_INPUT(rev_t), .JOG_INPUT(jog_t), .PREEXCITE_INPUT(pre_t), .COMM_RUN_CMD(crun),
    .COMM_STOP_CMD(1'b0), .COMM_REV_CMD(1'b0), .COMM_JOG_CMD(1'b0), .REMOTE_MODE(remote),
    .SRC_IND_KEYPAD(sind), .FREQ_IND_KEYPAD(find), .RUN(run), .REVERSE(rev), .JOG(jog),
    .DECEL_TO_ZERO(decel), .PREEXCITE(pre));
  // Clock and hang guard
  initial forever #2 clk = ~clk;
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  task chk(input string n, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", n, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle press: 0 toggle, 1 forward, 2 reverse, 3 link run
  task pulse(input int k);
    @(posedge clk);
    {crun, krev, kfwd, prog} <= 4'h1 << k;
    @(posedge clk);
    {crun, krev, kfwd, prog} <= 4'h0;
    #1;
  endtask
  task do_reset();
    @(posedge clk);
    rst <= 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    tick(2);
  endtask
  task report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    do_reset();
    chk("remote", 1, remote);
    pulse(0);
    chk("remote", 1, remote);
    fn <= LRCA_KEY_FN_LOCREM;
    pulse(0);
    chk("remote", 0, remote);
    chk("src_ind", 1, sind);
    chk("freq_ind", 1, find);
    fn <= 4'h0;
    pulse(0);
    chk("remote", 0, remote);
    fn <= LRCA_KEY_FN_LOCREM;
    tick(2);
    chk("remote", 1, remote);
    pulse(0);
    $display("test mode toggle done");
    for (int s = 0; s < 6; s++) begin
      src <= 3'(s);
      lvl <= {1'b1, s == 2, 2'b00, 11'h000};
      pulse(1);
      chk("local run", 1, run);
      pulse(0);
      chk("remote", 1, remote);
      chk("run", s == 1 || s == 2, run);
      chk("reverse", s == 2, rev);
      chk("src_ind", s == 0, sind);
      chk("freq_ind", 0, find);
      if (s == 0 || s > 2) pulse(s == 0 ? 1 : 3);
      chk("remote run", 1, run);
      pulse(0);
      chk("run", 0, run);
    end
    $display("test sources done");
    lvl <= 0;
    jogreq <= 1;
    tick(2);
    chk("jog", 0, jog);
    tmap[18+:6] <= LRCA_FN_RUN_PERMIT;
    lvl <= 15'h0008;
    tick(2);
    chk("jog", 1, jog);
    jogreq <= 0;
    dblk <= LRCA_BLK_REV;
    pulse(2);
    chk("decel", 1, decel);
    chk("run", 0, run);
    pulse(1);
    chk("run", 1, run);
    dblk <= LRCA_BLK_FWD;
    tick(2);
    chk("run", 0, run);
    dblk <= LRCA_BLK_NONE;
    pulse(2);
    chk("reverse", 1, rev);
    $display("test jog and direction done");
    src <= LRCA_SRC_TERM_FR;
    lvl <= 15'h4000;
    do_reset();
    tick(2);
    chk("run", 0, run);
    lvl <= 0;
    tick(2);
    lvl <= 15'h4000;
    tick(2);
    chk("run", 1, run);
    lvl <= 15'h5800;
    tick(2);
    chk("jog", 1, jog);
    chk("preexcite", 1, pre);
    lvl <= 15'h4000;
    tick(2);
    chk("preexcite", 0, pre);
    fault <= 1;
    do_reset();
    chk("remote", 0, remote);
    pulse(0);
    chk("run", 0, run);
    lvl <= 0;
    tick(2);
    lvl <= 15'h4000;
    tick(2);
    chk("run", 1, run);
    $display("test power-up done");
    report_and_stop();
  end
endmodule
// Port checker attached to every arbiter instance
bind lrca_arbiter lrca_arbiter_props #(.NUM_TERM(NUM_TERM)) u_lrca_arbiter_props (.*);
`default_nettype wire

// [bench/lrca_term_model.sv]
// Terminal block model: contact levels requested by the bench.
// Assumes no pull on the lines; contacts hold through power-up.
// Request order, top bit first: forward, reverse, jog, pre-excitation, terminals.
`timescale 1ns/10ps
`default_nettype none
module lrca_term_model #(
  parameter int NUM_TERM = 11
) (
  // Requested contact levels
  input  wire logic [NUM_TERM+3:0] set_lvl,
  // Lines toward the arbiter
  output logic                     fwd_run,
  output logic                     rev_run,
  output logic                     jog_in,
  output logic                     pre_in,
  output logic [NUM_TERM-1:0]      mfi
);
  // Every contact follows its request
  assign {fwd_run, rev_run, jog_in, pre_in, mfi} = set_lvl;
endmodule
`default_nettype wire

// [hw/lrca_arbiter.sv]
// Local/remote run command arbiter for a motor drive.
// Assumes all inputs are synchronous to CLK; settings held stable by firmware.
//
// Overview of operation
// RULE_01 - Key function 2: key press toggles mode
// RULE_02 - Enabling toggle function enters remote, keeps operation
// RULE_03 - To local: local indicator, keypad sources, stop
// RULE_04 - Back to remote restores configured source indication
// RULE_05 - Local jog needs asserted run-permit terminal
// RULE_06 - Remote uses configured command and frequency sources
// RULE_07 - No power-on run: inputs need release, reassert
// RULE_08 - Fault-reset power-up: local, stop on remote
// RULE_09 - Remote to local while running stops drive
// RULE_10 - To remote, terminal source keeps running per terminals
// RULE_11 - To remote, digital source stops until next command
// RULE_12 - Direction block: 0 none, 1 forward, 2 reverse
// RULE_13 - Blocked reverse key decelerates to zero, stops
// RULE_14 - Decode command source codes zero to five
// RULE_15 - One flag holds mode, drives indicator, selects source
`timescale 1ns/10ps
`default_nettype none
module lrca_arbiter
  import lrca_pkg::*;
#(
  parameter int NUM_TERM = LRCA_NUM_TERM
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST,
  // Configuration
  input  wire logic [3:0]            KEY_FUNCTION_SELECT,
  input  wire logic [2:0]            COMMAND_SOURCE_SELECT,
  input  wire logic                  POWER_ON_RUN_ENABLE,
  input  wire logic [1:0]            DIRECTION_BLOCK_SELECT,
  input  wire logic [NUM_TERM*6-1:0] TERMINAL_FUNCTION_MAP,
  input  wire logic                  FAULT_RESET_POWERUP,
  // Keypad
  input  wire logic                  KEY_PROG_PRESS,
  input  wire logic                  KEY_FWD_PRESS,
  input  wire logic                  KEY_REV_PRESS,
  input  wire logic                  KEY_STOP_PRESS,
  input  wire logic                  KEY_JOG_REQ,
  // Terminals
  input  wire logic [NUM_TERM-1:0]   MULTI_FUNCTION_INPUTS,
  input  wire logic                  FORWARD_RUN_INPUT,
  input  wire logic                  REVERSE_RUN_INPUT,
  input  wire logic                  JOG_INPUT,
  input  wire logic                  PREEXCITE_INPUT,
  // Communication sources
  input  wire logic                  COMM_RUN_CMD,
  input  wire logic                  COMM_STOP_CMD,
  input  wire logic                  COMM_REV_CMD,
  input  wire logic                  COMM_JOG_CMD,
  // Outputs
  output logic                       REMOTE_MODE,
  output logic                       SRC_IND_KEYPAD,
  output logic                       FREQ_IND_KEYPAD,
  output logic                       RUN,
  output logic                       REVERSE,
  output logic                       JOG,
  output logic                       DECEL_TO_ZERO,
  output logic                       PREEXCITE
);

  // Run permit: any terminal mapped to code 13 and asserted
  function automatic logic run_permit(input logic [NUM_TERM*6-1:0] map,
                                      input logic [NUM_TERM-1:0]   pins);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (map[i*6 +: 6] == LRCA_FN_RUN_PERMIT && pins[i]) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  logic remote_r, remote_nxt;
  logic armed_r, armed_nxt;
  logic run_r, run_nxt;
  logic rev_r, rev_nxt;
  logic jog_r, jog_nxt;
  logic decel_r, decel_nxt;
  logic pre_r, pre_nxt;
  logic keyfn_prev_r;
  logic started_r;

  // Source decode
  wire src_term     = (COMMAND_SOURCE_SELECT == LRCA_SRC_TERM_FR) ||
                      (COMMAND_SOURCE_SELECT == LRCA_SRC_TERM_RD);   // RULE_14
  wire src_keypad   = (COMMAND_SOURCE_SELECT == LRCA_SRC_KEYPAD);     // RULE_14
  wire src_comm     = (COMMAND_SOURCE_SELECT == LRCA_SRC_SERIAL) ||
                      (COMMAND_SOURCE_SELECT == LRCA_SRC_FIELDBUS) ||
                      (COMMAND_SOURCE_SELECT == LRCA_SRC_PLC);        // RULE_14
  wire toggle_en    = (KEY_FUNCTION_SELECT == LRCA_KEY_FN_LOCREM);
  wire toggle_start = toggle_en && !keyfn_prev_r;                     // RULE_02
  wire toggle       = toggle_en && KEY_PROG_PRESS;                    // RULE_01
  wire to_local     = toggle && remote_r;
  wire to_remote    = toggle && !remote_r;

  // Direction block decode
  wire blk_fwd      = (DIRECTION_BLOCK_SELECT == LRCA_BLK_FWD);       // RULE_12
  wire blk_rev      = (DIRECTION_BLOCK_SELECT == LRCA_BLK_REV);       // RULE_12

  // Terminal commands
  wire any_term     = FORWARD_RUN_INPUT || REVERSE_RUN_INPUT || JOG_INPUT || PREEXCITE_INPUT;
  wire t_run        = (COMMAND_SOURCE_SELECT == LRCA_SRC_TERM_FR) ?
                      (FORWARD_RUN_INPUT ^ REVERSE_RUN_INPUT) : FORWARD_RUN_INPUT;
  wire t_rev        = (COMMAND_SOURCE_SELECT == LRCA_SRC_TERM_FR) ?
                      (REVERSE_RUN_INPUT && !FORWARD_RUN_INPUT) : REVERSE_RUN_INPUT;
  wire permit       = run_permit(TERMINAL_FUNCTION_MAP, MULTI_FUNCTION_INPUTS);

  // Arming: terminal inputs count after all released
  always_comb begin
    armed_nxt = armed_r;
    if (!any_term) begin
      armed_nxt = 1'b1;                                               // RULE_07
    end
    if (to_remote && FAULT_RESET_POWERUP) begin
      armed_nxt = !any_term;                                          // RULE_08
    end
  end

  // Run arbitration
  always_comb begin
    remote_nxt = remote_r;
    run_nxt    = run_r;
    rev_nxt    = rev_r;
    jog_nxt    = 1'b0;
    decel_nxt  = 1'b0;
    pre_nxt    = 1'b0;
    if (toggle_start) begin
      remote_nxt = 1'b1;                                              // RULE_02
    end else if (to_local) begin
      remote_nxt = 1'b0;                                              // RULE_03
      run_nxt    = 1'b0;                                              // RULE_09
    end else if (to_remote) begin
      remote_nxt = 1'b1;                                              // RULE_04
      if (src_term && !FAULT_RESET_POWERUP && armed_r) begin
        run_nxt = t_run;                                              // RULE_10
        rev_nxt = t_rev;                                              // RULE_10
      end else begin
        run_nxt = 1'b0;                                               // RULE_11
      end
    end else if (!remote_r || src_keypad) begin
      // Keypad control
      if (KEY_STOP_PRESS) begin
        run_nxt = 1'b0;
      end else if (KEY_REV_PRESS && blk_rev) begin
        run_nxt   = 1'b0;                                             // RULE_13
        decel_nxt = 1'b1;                                             // RULE_13
      end else if (KEY_REV_PRESS) begin
        run_nxt = 1'b1;
        rev_nxt = 1'b1;
      end else if (KEY_FWD_PRESS && !blk_fwd) begin
        run_nxt = 1'b1;
        rev_nxt = 1'b0;
      end
      jog_nxt = KEY_JOG_REQ && (remote_r || permit);                  // RULE_05
    end else if (src_term) begin
      // Remote terminal control
      run_nxt = armed_r && t_run;                                     // RULE_06
      rev_nxt = t_rev;                                                // RULE_06
      jog_nxt = armed_r && JOG_INPUT;                                 // RULE_07
      pre_nxt = armed_r && PREEXCITE_INPUT;                           // RULE_07
    end else if (src_comm) begin
      // Remote communication control
      if (COMM_STOP_CMD) begin
        run_nxt = 1'b0;                                               // RULE_06
      end else if (COMM_RUN_CMD) begin
        run_nxt = 1'b1;                                               // RULE_06
        rev_nxt = COMM_REV_CMD;
      end
      jog_nxt = COMM_JOG_CMD;
    end
    // Blocked direction never runs
    if ((rev_nxt && blk_rev) || (!rev_nxt && blk_fwd)) begin
      if (run_nxt) begin
        decel_nxt = 1'b1;                                             // RULE_12
      end
      run_nxt = 1'b0;                                                 // RULE_12
      jog_nxt = 1'b0;
    end
  end

  // Mode and power-up state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      remote_r     <= LRCA_REMOTE_RST;
      armed_r      <= LRCA_ARMED_RST;
      keyfn_prev_r <= 1'b0;
      started_r    <= 1'b0;
    end else begin
      started_r    <= 1'b1;
      keyfn_prev_r <= toggle_en;
      // Fault-reset power-up enters local; otherwise mode flag follows toggles
      remote_r     <= (!started_r && FAULT_RESET_POWERUP) ? 1'b0 : remote_nxt; // RULE_08
      // Enabled power-on run arms immediately, except on fault-reset power-up
      armed_r      <= (!started_r && POWER_ON_RUN_ENABLE != LRCA_PON_RUN_OFF &&
                       !FAULT_RESET_POWERUP) ? 1'b1 : armed_nxt;                  // RULE_07
    end
  end

  // Drive command registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      run_r   <= 1'b0;
      rev_r   <= 1'b0;
      jog_r   <= 1'b0;
      decel_r <= 1'b0;
      pre_r   <= 1'b0;
    end else begin
      run_r   <= started_r ? run_nxt : 1'b0;
      rev_r   <= rev_nxt;
      jog_r   <= jog_nxt;
      decel_r <= decel_nxt;
      pre_r   <= pre_nxt;
    end
  end

  // Outputs
  assign REMOTE_MODE     = remote_r;                                  // RULE_15
  assign SRC_IND_KEYPAD  = !remote_r || src_keypad;                   // RULE_03
  assign FREQ_IND_KEYPAD = !remote_r;                                 // RULE_04
  assign RUN             = run_r;
  assign REVERSE         = rev_r;
  assign JOG             = jog_r;
  assign DECEL_TO_ZERO   = decel_r;
  assign PREEXCITE       = pre_r;

endmodule
`default_nettype wire

// [hw/lrca_pkg.sv]
// Package for the local/remote command arbiter: setting codes and sizes.
// Assumes settings arrive as plain synchronous ports.
package lrca_pkg;
  // Programmable key function code for local/remote toggling
  localparam logic [3:0] LRCA_KEY_FN_LOCREM   = 4'h2;
  // Command source codes
  localparam logic [2:0] LRCA_SRC_KEYPAD      = 3'h0;
  localparam logic [2:0] LRCA_SRC_TERM_FR     = 3'h1;
  localparam logic [2:0] LRCA_SRC_TERM_RD     = 3'h2;
  localparam logic [2:0] LRCA_SRC_SERIAL      = 3'h3;
  localparam logic [2:0] LRCA_SRC_FIELDBUS    = 3'h4;
  localparam logic [2:0] LRCA_SRC_PLC         = 3'h5;
  // Direction block codes
  localparam logic [1:0] LRCA_BLK_NONE        = 2'h0;
  localparam logic [1:0] LRCA_BLK_FWD         = 2'h1;
  localparam logic [1:0] LRCA_BLK_REV         = 2'h2;
  // Terminal function code for run permit
  localparam logic [5:0] LRCA_FN_RUN_PERMIT   = 6'h0D;
  // Power-on run disabled setting
  localparam logic       LRCA_PON_RUN_OFF     = 1'b0;
  // Number of multi-function terminals
  localparam int         LRCA_NUM_TERM        = 11;
  // Values after reset
  localparam logic       LRCA_REMOTE_RST      = 1'b1;
  localparam logic       LRCA_ARMED_RST       = 1'b0;
endpackage
